// ### core/occ_top.sv
// Output driver enable, disable level, polarity and phase control
//
// How it works
// - Off pin high disables all outputs
// - Pin low: each output still register-disableable
// - Single-ended drives both pins, in phase
// - Each single-ended pin has polarity invert
// - Unlock leaves outputs running by default
// - Optional: unlock disables outputs while unlocked
// - Reference loss disables outputs by default
// - Option keeps outputs on during reference loss
// - Disabled output holds selected low/high level
// - Sync disable waits for period end
// - Async disable stops clock at once
// - Static phase offset loaded per output
// - Dynamic step writes shift phase glitchlessly
// - Dividers reset aligned after power-up
// - Reset pin or hard bit realigns dividers
// - Zero delay: external feedback replaces internal
// - Unlock indication drives unlock disable
// - Reference alarm means reference invalid
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "occ_defs.svh"
module occ_top
	import occ_pkg::*;
(
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_b,
	// Device pins
	input  wire logic                 all_outputs_off_pin,
	input  wire logic                 pll_unlocked,
	input  wire logic                 reference_lost_alarm,
	input  wire logic                 feedback_input,
	// Register port
	input  wire logic [`OCC_AW-1:0]   reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [31:0]          reg_rdata,
	// Output drivers
	output logic      [`OCC_NOUT-1:0] out_true_pin,
	output logic      [`OCC_NOUT-1:0] out_comp_pin,
	// Loop feedback
	output logic                      loop_feedback,
	output logic                      feedback_loop_open
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Half period minus one, zero counts as one cycle
	function automatic logic [`OCC_DW-1:0] half_m1(
		input logic [`OCC_DW-1:0] h
	);
		half_m1 = (h == '0) ? '0 : h - `OCC_DW'h1;
	endfunction

	// Output bank hit
	function automatic logic is_out(input logic [`OCC_AW-1:0] a);
		is_out = (a[7:6] == `OCC_A_OUTBANK);
	endfunction

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic [1:0]          rst_s;
	logic                rst_q;
	occ_state_type       s_q;
	occ_state_type       s_d;
	logic [`OCC_NOUT-1:0] dis;
	logic [`OCC_NOUT-1:0] bnd;
	logic                div_rst;

	// Two-stage release of the async reset
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			rst_s <= 2'h0;
		else
			rst_s <= {rst_s[0], 1'b1};
	end
	assign rst_q = rst_s[1];

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Pin sync, registers, dividers, gating and drivers
	always_comb
	begin
		logic [`OCC_DW-1:0] hm;
		logic [`OCC_DW-1:0] p;
		logic [1:0]         ri;
		logic [1:0]         oi;
		hm = '0;
		p = '0;
		ri = reg_addr[3:2];
		oi = reg_addr[5:4];
		s_d = s_q;
		dis = '0;
		bnd = '0;
		s_d.s1 = {feedback_input, reference_lost_alarm,
			pll_unlocked, all_outputs_off_pin};
		s_d.s2 = s_q.s1;
		s_d.rdata = '0;
		s_d.run = 1'b1;
		div_rst = !s_q.run;
		// Register writes
		if (reg_wr)
		begin
			if (reg_addr == `OCC_A_CTRL)
			begin
				s_d.unlk_en = reg_wdata[`OCC_C_UNLK];
				s_d.keep_los = reg_wdata[`OCC_C_KEEP];
				s_d.zdm = reg_wdata[`OCC_C_ZDM];
				if (reg_wdata[`OCC_C_HRST])
					div_rst = 1'b1;
			end
			else if (reg_addr == `OCC_A_FBSEL)
				s_d.fb_sel = reg_wdata[1:0];
			else if (is_out(reg_addr))
			begin
				case (ri)
					`OCC_R_CFG:
						s_d.cfg[oi] = reg_wdata[`OCC_CFGW-1:0];
					`OCC_R_DIV:
						s_d.half[oi] = reg_wdata[`OCC_DW-1:0];
					`OCC_R_SOFF:
						s_d.soff[oi] = reg_wdata[`OCC_DW-1:0];
					default:
						s_d.pend[oi] = s_q.pend[oi]
							+ reg_wdata[`OCC_DW-1:0];
				endcase
			end
		end
		// Per-output divider, gate and driver
		for (int i = 0; i < `OCC_NOUT; i++)
		begin
			hm = half_m1(s_q.half[i]);
			p = s_d.pend[i];
			dis[i] = s_q.s2[`OCC_P_OFF]
				| s_q.cfg[i][`OCC_F_DIS]
				| (s_q.unlk_en & s_q.s2[`OCC_P_UNLK])
				| (!s_q.keep_los & s_q.s2[`OCC_P_LOS]);
			if (div_rst)
			begin
				// Aligned start, static offset as pending shift
				s_d.cnt[i] = '0;
				s_d.clk[i] = 1'b0;
				s_d.pend[i] = s_q.soff[i];
			end
			else if (!s_q.clk[i] && s_q.cnt[i] >= hm
				&& $signed(p) > 0)
			begin
				// Delay: stretch low phase one cycle
				s_d.pend[i] = p - `OCC_DW'h1;
			end
			else if (!s_q.clk[i] && s_q.cnt[i] + `OCC_DW'h1 < hm
				&& $signed(p) < 0)
			begin
				// Advance: shorten low phase one cycle
				s_d.cnt[i] = s_q.cnt[i] + `OCC_DW'h2;
				s_d.pend[i] = p + `OCC_DW'h1;
			end
			else if (s_q.cnt[i] >= hm)
			begin
				s_d.cnt[i] = '0;
				s_d.clk[i] = !s_q.clk[i];
				bnd[i] = !s_q.clk[i];
			end
			else
				s_d.cnt[i] = s_q.cnt[i] + `OCC_DW'h1;
			// Gate follows the request, at period end if sync
			if (dis[i] != s_q.gated[i])
			begin
				if (!s_q.cfg[i][`OCC_F_SYNC])
					s_d.gated[i] = dis[i];
				else if (bnd[i] || div_rst)
					s_d.gated[i] = dis[i];
			end
			// Drivers: level when gated, else clock with polarity
			if (s_d.gated[i])
			begin
				s_d.out_t[i] = s_q.cfg[i][`OCC_F_LVL];
				s_d.out_c[i] = s_q.cfg[i][`OCC_F_SE]
					? s_q.cfg[i][`OCC_F_LVL]
					: !s_q.cfg[i][`OCC_F_LVL];
			end
			else
			begin
				s_d.out_t[i] = s_d.clk[i]
					^ s_q.cfg[i][`OCC_F_INVT];
				s_d.out_c[i] = s_q.cfg[i][`OCC_F_SE]
					? s_d.clk[i] ^ s_q.cfg[i][`OCC_F_INVC]
					: !s_d.clk[i];
			end
		end
		// Loop feedback source
		s_d.fbk = s_q.zdm ? s_q.s2[`OCC_P_FB]
			: s_q.clk[s_q.fb_sel];
		// Register reads
		if (reg_rd)
		begin
			if (reg_addr == `OCC_A_CTRL)
			begin
				s_d.rdata[`OCC_C_UNLK] = s_q.unlk_en;
				s_d.rdata[`OCC_C_KEEP] = s_q.keep_los;
				s_d.rdata[`OCC_C_ZDM] = s_q.zdm;
			end
			else if (reg_addr == `OCC_A_FBSEL)
				s_d.rdata[1:0] = s_q.fb_sel;
			else if (reg_addr == `OCC_A_STAT)
			begin
				s_d.rdata[3:0] = s_q.s2;
				s_d.rdata[`OCC_S_DIS +: `OCC_NOUT] = dis;
				s_d.rdata[`OCC_S_GATE +: `OCC_NOUT] = s_q.gated;
			end
			else if (is_out(reg_addr))
			begin
				case (ri)
					`OCC_R_CFG:
						s_d.rdata[`OCC_CFGW-1:0] = s_q.cfg[oi];
					`OCC_R_DIV:
						s_d.rdata[`OCC_DW-1:0] = s_q.half[oi];
					`OCC_R_SOFF:
						s_d.rdata[`OCC_DW-1:0] = s_q.soff[oi];
					default:
						s_d.rdata[`OCC_DW-1:0] = s_q.pend[oi];
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Whole state on the released reset
	always_ff @(posedge core_clk or negedge rst_q)
	begin
		if (!rst_q)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// Outputs straight from flops
	assign reg_rdata = s_q.rdata;
	assign out_true_pin = s_q.out_t;
	assign out_comp_pin = s_q.out_c;
	assign loop_feedback = s_q.fbk;
	assign feedback_loop_open = s_q.zdm;

	// ------------------------------------------------------------
	// Checks on output 0 and the loop feedback
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_q);

	chk_pin_off_now: assert property (
		s_q.s2[`OCC_P_OFF] && !s_q.cfg[0][`OCC_F_SYNC] && !div_rst
		|=> s_q.gated[0]) else $error("pin off not applied");
	chk_reg_off_now: assert property (
		s_q.cfg[0][`OCC_F_DIS] && !s_q.cfg[0][`OCC_F_SYNC]
		|=> s_q.gated[0]) else $error("register disable ignored");
	chk_se_inphase: assert property (
		!s_q.gated[0] && s_q.cfg[0][`OCC_F_SE]
		&& s_q.cfg[0][`OCC_F_INVT] == s_q.cfg[0][`OCC_F_INVC]
		&& $stable(s_q.cfg[0])
		|-> s_q.out_t[0] == s_q.out_c[0]) else $error("pins differ");
	chk_se_invert: assert property (
		!s_q.gated[0] && s_q.cfg[0][`OCC_F_SE]
		&& s_q.cfg[0][`OCC_F_INVT] != s_q.cfg[0][`OCC_F_INVC]
		&& $stable(s_q.cfg[0])
		|-> s_q.out_t[0] != s_q.out_c[0]) else $error("no invert");
	chk_unlock_run: assert property (
		!s_q.unlk_en && !s_q.s2[`OCC_P_OFF]
		&& !s_q.cfg[0][`OCC_F_DIS]
		&& (s_q.keep_los || !s_q.s2[`OCC_P_LOS]) |-> !dis[0])
		else $error("unlock disabled output");
	chk_unlock_off: assert property (
		s_q.unlk_en && s_q.s2[`OCC_P_UNLK] |-> dis[0])
		else $error("unlock disable missing");
	chk_los_off: assert property (
		!s_q.keep_los && s_q.s2[`OCC_P_LOS] |-> dis[0])
		else $error("reference loss not disabling");
	chk_los_keep: assert property (
		s_q.keep_los && !s_q.unlk_en && !s_q.s2[`OCC_P_OFF]
		&& !s_q.cfg[0][`OCC_F_DIS] |-> !dis[0])
		else $error("reference loss disabled output");
	chk_off_level: assert property (
		s_q.gated[0] && $past(s_q.gated[0]) && $stable(s_q.cfg[0])
		|-> s_q.out_t[0] == s_q.cfg[0][`OCC_F_LVL])
		else $error("wrong disabled level");
	chk_sync_wait: assert property (
		dis[0] && !s_q.gated[0] && s_q.cfg[0][`OCC_F_SYNC]
		&& !bnd[0] && !div_rst |=> !s_q.gated[0])
		else $error("sync disable cut period");
	chk_div_align: assert property (
		div_rst |=> s_q.cnt[0] == '0 && !s_q.clk[0]
		&& s_q.pend[0] == $past(s_q.soff[0]))
		else $error("divider not realigned");
	chk_hard_reset: assert property (
		reg_wr && reg_addr == `OCC_A_CTRL && reg_wdata[`OCC_C_HRST]
		|=> s_q.cnt[0] == '0) else $error("hard reset missed");
	chk_fb_route: assert property (
		s_q.zdm && $past(s_q.zdm)
		|=> s_q.fbk == $past(s_q.s2[`OCC_P_FB]))
		else $error("feedback not external");

	// Main scenarios
	cov_sync_off: cover property (
		s_q.cfg[0][`OCC_F_SYNC] && !s_q.gated[0] ##1 s_q.gated[0]);
	cov_phase_shift: cover property (
		s_q.pend[0] != '0 ##1 s_q.pend[0] == '0);
	cov_zero_delay: cover property (s_q.zdm && s_q.fbk);
endmodule
`default_nettype wire

// ### core/occ_defs.svh
// Constants for the output clock gating and phase control block
`ifndef OCC_DEFS_SVH
`define OCC_DEFS_SVH
// ------------------------------------------------------------
// Sizes
// ------------------------------------------------------------
`define OCC_NOUT 4
`define OCC_DW 16
`define OCC_AW 8
`define OCC_CFGW 6
// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define OCC_A_CTRL 8'h00
`define OCC_A_FBSEL 8'h04
`define OCC_A_STAT 8'h08
`define OCC_A_OUTBANK 2'h1
`define OCC_R_CFG 2'h0
`define OCC_R_DIV 2'h1
`define OCC_R_SOFF 2'h2
`define OCC_R_DYN 2'h3
// ------------------------------------------------------------
// Control register bits
// ------------------------------------------------------------
`define OCC_C_UNLK 0
`define OCC_C_KEEP 1
`define OCC_C_HRST 2
`define OCC_C_ZDM 3
// ------------------------------------------------------------
// Per-output config bits
// ------------------------------------------------------------
`define OCC_F_DIS 0
`define OCC_F_LVL 1
`define OCC_F_SYNC 2
`define OCC_F_SE 3
`define OCC_F_INVT 4
`define OCC_F_INVC 5
// ------------------------------------------------------------
// Synced pin positions and status fields
// ------------------------------------------------------------
`define OCC_P_OFF 0
`define OCC_P_UNLK 1
`define OCC_P_LOS 2
`define OCC_P_FB 3
`define OCC_S_DIS 8
`define OCC_S_GATE 12
`endif

// ### core/occ_pkg.sv
// Types for the output clock gating and phase control block
`include "occ_defs.svh"
package occ_pkg;
	// ------------------------------------------------------------
	// Whole block state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0]                          s1;
		logic [3:0]                          s2;
		logic                                run;
		logic                                unlk_en;
		logic                                keep_los;
		logic                                zdm;
		logic [1:0]                          fb_sel;
		logic                                fbk;
		logic [`OCC_NOUT-1:0][`OCC_CFGW-1:0] cfg;
		logic [`OCC_NOUT-1:0][`OCC_DW-1:0]   half;
		logic [`OCC_NOUT-1:0][`OCC_DW-1:0]   soff;
		logic [`OCC_NOUT-1:0][`OCC_DW-1:0]   pend;
		logic [`OCC_NOUT-1:0][`OCC_DW-1:0]   cnt;
		logic [`OCC_NOUT-1:0]                clk;
		logic [`OCC_NOUT-1:0]                gated;
		logic [`OCC_NOUT-1:0]                out_t;
		logic [`OCC_NOUT-1:0]                out_c;
		logic [31:0]                         rdata;
	} occ_state_type;
endpackage

// ### tb/occ_rx_model.sv
// Downstream receiver model that also closes the external loop
`timescale 1ns/1ps
`default_nettype none
module occ_rx_model
(
	// Clock
	input  wire logic        core_clk,
	// Driver side
	input  wire logic        rx_clk,
	output logic             fb_out,
	// Observation
	output logic      [15:0] edge_cnt
);
	logic prev_q;

	// Received clock routed back as loop feedback
	assign fb_out = rx_clk;

	// Count rising edges seen by the receiver
	initial
	begin
		prev_q = 1'b0;
		edge_cnt = 16'h0000;
	end
	always @(posedge core_clk)
	begin
		prev_q <= rx_clk;
		if (rx_clk && !prev_q)
			edge_cnt <= edge_cnt + 16'h0001;
	end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the output clock gating block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        core_clk, rst_b, off, unlk, los, fb, reg_wr, reg_rd;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic        loop_fb, loop_open;
	logic [3:0]  ot, oc;
	logic [15:0] ec, e0;
	int          fails, total_checks;

	occ_top occ_top_i (.core_clk(core_clk), .rst_b(rst_b),
		.all_outputs_off_pin(off), .pll_unlocked(unlk),
		.reference_lost_alarm(los), .feedback_input(fb),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_true_pin(ot),
		.out_comp_pin(oc), .loop_feedback(loop_fb),
		.feedback_loop_open(loop_open));
	occ_rx_model occ_rx_model_i (.core_clk(core_clk), .rx_clk(ot[0]),
		.fb_out(fb), .edge_cnt(ec));

	// Clock
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Register port cycles
	task automatic wr_now(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		wr_now(a, v);
		wt(4);
	endtask

	// Data taken mid cycle, task ends on a rising edge
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
		@(posedge core_clk);
	endtask

	// Output 0 toggling over ten cycles or not
	task automatic run(input logic exp);
		e0 = ec;
		wt(10);
		chk(ec != e0, exp);
	endtask

	// Wait until output 0 has just gone high
	task automatic wait_high;
		do
			@(negedge core_clk);
		while (ot[0] !== 1'b0);
		do
			@(negedge core_clk);
		while (ot[0] !== 1'b1);
	endtask

	task automatic t_pin;
		@(posedge core_clk);
		off <= 1'b1;
		wt(6);
		@(negedge core_clk);
		chk(ot[0], 0);
		chk(oc[0], 1);
		run(0);
		wr(8'h40, 32'h00000002);
		chk(ot[0], 1);
		@(posedge core_clk);
		off <= 1'b0;
		wr(8'h40, 32'h00000000);
		run(1);
		$display("pin test done");
	endtask

	task automatic t_reg;
		wr(8'h40, 32'h00000001);
		run(0);
		rd(8'h08);
		chk(d[8], 1);
		chk(d[9], 0);
		chk(d[3:0], 0);
		wr(8'h40, 32'h00000000);
		run(1);
		@(negedge core_clk);
		chk(ot[0], ot[1]);
		rd(8'hf0);
		chk(d, 0);
		$display("register disable test done");
	endtask

	// Dynamic step, static offset, hard bit and reset pin
	task automatic t_phase;
		wr(8'h4c, 32'h00000001);
		@(negedge core_clk);
		chk(ot[0], !ot[1]);
		rd(8'h4c);
		chk(d[15:0], 0);
		wr(8'h48, 32'h00000001);
		wr(8'h00, 32'h00000004);
		@(negedge core_clk);
		chk(ot[0], !ot[1]);
		@(posedge core_clk);
		rst_b <= 1'b0;
		wt(2);
		rst_b <= 1'b1;
		wt(3);
		@(negedge core_clk);
		chk(ot[0], 0);
		wt(3);
		@(negedge core_clk);
		chk(ot[0], ot[1]);
		$display("phase and reset test done");
	endtask

	task automatic t_fault;
		@(posedge core_clk);
		unlk <= 1'b1;
		wt(4);
		run(1);
		wr(8'h00, 32'h00000001);
		run(0);
		rd(8'h08);
		chk(d[1], 1);
		@(posedge core_clk);
		unlk <= 1'b0;
		los <= 1'b1;
		wr(8'h00, 32'h00000000);
		run(0);
		rd(8'h08);
		chk(d[2], 1);
		wr(8'h00, 32'h00000002);
		run(1);
		@(posedge core_clk);
		los <= 1'b0;
		wr(8'h00, 32'h00000000);
		$display("fault test done");
	endtask

	// Disable in the high phase of a four cycle half period
	task automatic t_sync;
		wr(8'h44, 32'h00000004);
		wait_high;
		wr_now(8'h40, 32'h00000001);
		@(negedge core_clk);
		@(negedge core_clk);
		chk(ot[0], 0);
		wr(8'h40, 32'h00000000);
		wait_high;
		wr_now(8'h40, 32'h00000005);
		@(negedge core_clk);
		@(negedge core_clk);
		chk(ot[0], 1);
		run(0);
		wr(8'h40, 32'h00000000);
		wr(8'h44, 32'h00000000);
		$display("synchronous disable test done");
	endtask

	task automatic t_se;
		wr(8'h40, 32'h00000008);
		repeat (3)
		begin
			@(negedge core_clk);
			chk(oc[0], ot[0]);
		end
		wr(8'h40, 32'h00000028);
		repeat (3)
		begin
			@(negedge core_clk);
			chk(oc[0], !ot[0]);
		end
		wr(8'h40, 32'h00000000);
		$display("single ended test done");
	endtask

	task automatic t_zdm;
		logic f;
		wr(8'h04, 32'h00000001);
		rd(8'h04);
		chk(d[1:0], 1);
		wr(8'h40, 32'h00000003);
		@(negedge core_clk);
		f = loop_fb;
		@(negedge core_clk);
		chk(loop_fb, !f);
		wr(8'h00, 32'h00000008);
		chk(loop_open, 1);
		@(negedge core_clk);
		chk(loop_fb, 1);
		wr(8'h40, 32'h00000001);
		wt(2);
		@(negedge core_clk);
		chk(loop_fb, 0);
		wr(8'h40, 32'h00000000);
		wr(8'h00, 32'h0000000c);
		rd(8'h00);
		chk(d[3:2], 2'h2);
		@(negedge core_clk);
		chk(ot[0], ot[1]);
		run(1);
		$display("zero delay test done");
	endtask

	// Watchdog
	initial
	begin
		#100us;
		fails++;
		end_of_test;
	end

	// Main sequence
	initial
	begin
		{rst_b, off, unlk, los, reg_wr, reg_rd} = 6'h00;
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		fails = 0;
		total_checks = 0;
		wt(4);
		rst_b <= 1'b1;
		wt(3);
		rd(8'h00);
		chk(d, 0);
		@(negedge core_clk);
		chk(ot[0], ot[1]);
		t_pin;
		t_reg;
		t_phase;
		t_fault;
		t_sync;
		t_se;
		t_zdm;
		end_of_test;
	end
endmodule
`default_nettype wire
